// ---- verilog/ioxp_expander.sv ----
module ioxp_expander (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic RESET_N,
   input wire logic ADDR_SEL,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_N,
   output logic INT_O,
   output logic INT_OE_N,
   input wire logic [ioxp_pkg::NPIN-1:0] P_I,
   output logic [ioxp_pkg::NPIN-1:0] P_O,
   output logic [ioxp_pkg::NPIN-1:0] P_OE_N,
   output logic [2*ioxp_pkg::NPIN-1:0] P_DRIVE,
   output logic [ioxp_pkg::NPIN-1:0] P_PULL_EN,
   output logic [ioxp_pkg::NPIN-1:0] P_PULL_UP
);
   import ioxp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers
   logic [2:0] scl_s, sda_s;
   logic [1:0] rstn_s, adr_s;
   logic [NPIN-1:0] pin_s1, pin_s2;
   logic rst_all;

   always_ff @(posedge CLOCK) begin
      scl_s <= {scl_s[1:0], SCL_I};
      sda_s <= {sda_s[1:0], SDA_I};
      adr_s <= {adr_s[0], ADDR_SEL};
      pin_s1 <= P_I;
      pin_s2 <= pin_s1;
      if (RST) begin
         rstn_s <= 2'h0;
      end else begin
         rstn_s <= {rstn_s[0], RESET_N};
      end
   end

   assign rst_all = RST | ~rstn_s[1];

   ////////////////////////////////////////////////////////////////////////////
   // state
   ioxp_state_e state, next_state;
   ioxp_regs_s r, next_r;
   logic [7:0] shift, next_shift, ptr, next_ptr;
   logic [3:0] bitcnt, next_bitcnt;
   logic rw, next_rw, nack, next_nack, sda_oe_n, next_sda_oe_n;
   logic [NPIN-1:0] ref_v, next_ref_v, pend, next_pend, hold, next_hold;
   logic [NPIN-1:0] next_p_oe_n;
   logic next_int_oe_n;

   logic scl_rise, scl_fall, start_c, stop_c;
   logic [6:0] my_addr;
   logic [NPIN-1:0] changed, status, in_val, rd_clear;

   assign scl_rise = scl_s[1] & ~scl_s[2];
   assign scl_fall = ~scl_s[1] & scl_s[2];
   assign start_c = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
   assign stop_c = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
   assign my_addr = adr_s[1] ? TARGET_ADDR_HIGH : TARGET_ADDR_LOW;

   // only pins set as inputs can raise a change
   assign changed = r.dir & (pin_s2 ^ ref_v);
   assign status = (r.latch & pend) | (~r.latch & changed & ~r.mask);
   assign in_val = ((r.latch & pend & hold) | (~(r.latch & pend) & pin_s2)) ^ r.pol;

   function automatic logic [7:0] read_byte(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         CMD_INPUT0: v = in_val[7:0];
         CMD_INPUT1: v = in_val[15:8];
         CMD_OUTPUT0: v = r.outv[7:0];
         CMD_OUTPUT1: v = r.outv[15:8];
         CMD_POLARITY0: v = r.pol[7:0];
         CMD_POLARITY1: v = r.pol[15:8];
         CMD_DIR0: v = r.dir[7:0];
         CMD_DIR1: v = r.dir[15:8];
         CMD_DRIVE0: v = r.drive[7:0];
         CMD_DRIVE1: v = r.drive[15:8];
         CMD_DRIVE2: v = r.drive[23:16];
         CMD_DRIVE3: v = r.drive[31:24];
         CMD_LATCH0: v = r.latch[7:0];
         CMD_LATCH1: v = r.latch[15:8];
         CMD_PULLEN0: v = r.pull_en[7:0];
         CMD_PULLEN1: v = r.pull_en[15:8];
         CMD_PULLUP0: v = r.pull_up[7:0];
         CMD_PULLUP1: v = r.pull_up[15:8];
         CMD_MASK0: v = r.mask[7:0];
         CMD_MASK1: v = r.mask[15:8];
         CMD_STATUS0: v = status[7:0];
         CMD_STATUS1: v = status[15:8];
         CMD_OUTTYPE: v = {6'h00, r.open_drain};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      next_state = state;
      next_r = r;
      next_shift = shift;
      next_ptr = ptr;
      next_bitcnt = bitcnt;
      next_rw = rw;
      next_nack = nack;
      next_sda_oe_n = sda_oe_n;
      rd_clear = '0;
      if (start_c) begin
         next_state = ST_ADDR;
         next_bitcnt = 4'h0;
         next_sda_oe_n = 1'b1;
      end else if (stop_c) begin
         next_state = ST_IDLE;
         next_sda_oe_n = 1'b1;
      end else begin
         case (state)
            ST_ADDR, ST_CMD, ST_WR: begin
               if (scl_rise) begin
                  next_shift = {shift[6:0], sda_s[1]};
                  next_bitcnt = bitcnt + 4'h1;
               end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
                  next_bitcnt = 4'h0;
                  next_sda_oe_n = 1'b0;
                  if (state == ST_ADDR) begin
                     next_rw = shift[0];
                     if (shift[7:1] == my_addr) begin
                        next_state = ST_ADDR_ACK;
                     end else begin
                        next_state = ST_IGNORE;
                        next_sda_oe_n = 1'b1;
                     end
                  end else if (state == ST_CMD) begin
                     next_ptr = shift;
                     next_state = ST_CMD_ACK;
                  end else begin
                     next_state = ST_WR_ACK;
                     next_ptr = {ptr[7:1], ~ptr[0]};
                     case (ptr)
                        CMD_OUTPUT0: next_r.outv[7:0] = shift;
                        CMD_OUTPUT1: next_r.outv[15:8] = shift;
                        CMD_POLARITY0: next_r.pol[7:0] = shift;
                        CMD_POLARITY1: next_r.pol[15:8] = shift;
                        CMD_DIR0: next_r.dir[7:0] = shift;
                        CMD_DIR1: next_r.dir[15:8] = shift;
                        CMD_DRIVE0: next_r.drive[7:0] = shift;
                        CMD_DRIVE1: next_r.drive[15:8] = shift;
                        CMD_DRIVE2: next_r.drive[23:16] = shift;
                        CMD_DRIVE3: next_r.drive[31:24] = shift;
                        CMD_LATCH0: next_r.latch[7:0] = shift;
                        CMD_LATCH1: next_r.latch[15:8] = shift;
                        CMD_PULLEN0: next_r.pull_en[7:0] = shift;
                        CMD_PULLEN1: next_r.pull_en[15:8] = shift;
                        CMD_PULLUP0: next_r.pull_up[7:0] = shift;
                        CMD_PULLUP1: next_r.pull_up[15:8] = shift;
                        CMD_MASK0: next_r.mask[7:0] = shift;
                        CMD_MASK1: next_r.mask[15:8] = shift;
                        CMD_OUTTYPE: next_r.open_drain = shift[1:0];
                        default: next_r = r;
                     endcase
                  end
               end
            end
            ST_ADDR_ACK, ST_CMD_ACK, ST_WR_ACK, ST_RD_ACK: begin
               if (scl_rise && state == ST_RD_ACK) begin
                  next_nack = sda_s[1];
               end else if (scl_fall) begin
                  next_sda_oe_n = 1'b1;
                  if (state == ST_CMD_ACK || state == ST_WR_ACK) begin
                     next_state = ST_WR;
                  end else if (state == ST_ADDR_ACK && !rw) begin
                     next_state = ST_CMD;
                  end else if (state == ST_RD_ACK && nack) begin
                     next_state = ST_IGNORE;
                  end else begin
                     next_state = ST_RD;
                     next_shift = read_byte(ptr);
                     next_sda_oe_n = next_shift[7];
                     next_ptr = {ptr[7:1], ~ptr[0]};
                     if (ptr == CMD_INPUT0) rd_clear[7:0] = 8'hFF;
                     if (ptr == CMD_INPUT1) rd_clear[15:8] = 8'hFF;
                  end
               end
            end
            ST_RD: begin
               if (scl_fall) begin
                  if (bitcnt == LAST_BIT) begin
                     next_state = ST_RD_ACK;
                     next_sda_oe_n = 1'b1;
                     next_bitcnt = 4'h0;
                  end else begin
                     next_shift = {shift[6:0], 1'b0};
                     next_sda_oe_n = shift[6];
                     next_bitcnt = bitcnt + 4'h1;
                  end
               end
            end
            ST_IGNORE, ST_IDLE: next_sda_oe_n = 1'b1;
            default: next_state = ST_IDLE;
         endcase
      end
   end

   // input reference, latching and alert; on a latched pin a new change outranks a same-cycle read, unlatched the read wins
   always_comb begin
      next_ref_v = (ref_v & ~rd_clear) | (pin_s2 & rd_clear);
      next_pend = pend & ~rd_clear;
      next_hold = hold;
      next_pend = next_pend | (changed & r.latch & ~pend);
      next_hold = (hold & ~(changed & r.latch & ~pend)) | (pin_s2 & changed & r.latch & ~pend);
      next_int_oe_n = ~|status;
      // open drain never drives a high; it leaves the pin to the pull
      next_p_oe_n = ~(~next_r.dir & ~({{8{next_r.open_drain[1]}}, {8{next_r.open_drain[0]}}} & next_r.outv));
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge CLOCK) begin
      if (rst_all) begin
         state <= ST_IDLE;
         r <= REGS_RESET;
         shift <= 8'h00;
         ptr <= 8'h00;
         bitcnt <= 4'h0;
         rw <= 1'b0;
         nack <= 1'b1;
         sda_oe_n <= 1'b1;
         ref_v <= '0;
         pend <= '0;
         hold <= '0;
         SDA_O <= 1'b0;
         SDA_OE_N <= 1'b1;
         INT_O <= 1'b0;
         INT_OE_N <= 1'b1;
         P_O <= REGS_RESET.outv;
         P_OE_N <= REGS_RESET.dir;
         P_DRIVE <= REGS_RESET.drive;
         P_PULL_EN <= REGS_RESET.pull_en;
         P_PULL_UP <= REGS_RESET.pull_up;
      end else begin
         state <= next_state;
         r <= next_r;
         shift <= next_shift;
         ptr <= next_ptr;
         bitcnt <= next_bitcnt;
         rw <= next_rw;
         nack <= next_nack;
         sda_oe_n <= next_sda_oe_n;
         ref_v <= next_ref_v;
         pend <= next_pend;
         hold <= next_hold;
         SDA_O <= 1'b0;
         SDA_OE_N <= next_sda_oe_n;
         INT_O <= 1'b0;
         INT_OE_N <= next_int_oe_n;
         P_O <= next_r.outv;
         P_OE_N <= next_p_oe_n;
         P_DRIVE <= next_r.drive;
         P_PULL_EN <= next_r.pull_en;
         P_PULL_UP <= next_r.pull_up;
      end
   end

endmodule // ioxp_expander

// ---- verilog/ioxp_pkg.sv ----
package ioxp_pkg;

   localparam int NPIN = 16;

   // two target addresses, picked by the address-select pin
   localparam logic [6:0] TARGET_ADDR_LOW = 7'h20;
   localparam logic [6:0] TARGET_ADDR_HIGH = 7'h21;

   // command byte codes, one byte per 8-pin bank (bank 0 even, bank 1 odd), except drive (two per bank) and output type (one for both)
   localparam logic [7:0] CMD_INPUT0 = 8'h00;
   localparam logic [7:0] CMD_INPUT1 = 8'h01;
   localparam logic [7:0] CMD_OUTPUT0 = 8'h02;
   localparam logic [7:0] CMD_OUTPUT1 = 8'h03;
   localparam logic [7:0] CMD_POLARITY0 = 8'h04;
   localparam logic [7:0] CMD_POLARITY1 = 8'h05;
   localparam logic [7:0] CMD_DIR0 = 8'h06;
   localparam logic [7:0] CMD_DIR1 = 8'h07;
   localparam logic [7:0] CMD_DRIVE0 = 8'h40;
   localparam logic [7:0] CMD_DRIVE1 = 8'h41;
   localparam logic [7:0] CMD_DRIVE2 = 8'h42;
   localparam logic [7:0] CMD_DRIVE3 = 8'h43;
   localparam logic [7:0] CMD_LATCH0 = 8'h44;
   localparam logic [7:0] CMD_LATCH1 = 8'h45;
   localparam logic [7:0] CMD_PULLEN0 = 8'h46;
   localparam logic [7:0] CMD_PULLEN1 = 8'h47;
   localparam logic [7:0] CMD_PULLUP0 = 8'h48;
   localparam logic [7:0] CMD_PULLUP1 = 8'h49;
   localparam logic [7:0] CMD_MASK0 = 8'h4A;
   localparam logic [7:0] CMD_MASK1 = 8'h4B;
   localparam logic [7:0] CMD_STATUS0 = 8'h4C;
   localparam logic [7:0] CMD_STATUS1 = 8'h4D;
   localparam logic [7:0] CMD_OUTTYPE = 8'h4F;

   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;

   typedef enum {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
      ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_IGNORE
   } ioxp_state_e;

   typedef struct packed {
      logic [15:0] outv;
      logic [15:0] pol;
      logic [15:0] dir;
      logic [31:0] drive;
      logic [15:0] latch;
      logic [15:0] pull_en;
      logic [15:0] pull_up;
      logic [15:0] mask;
      logic [1:0] open_drain;
   } ioxp_regs_s;

   localparam ioxp_regs_s REGS_RESET = '{
      outv: 16'hFFFF, pol: 16'h0000, dir: 16'hFFFF, drive: 32'hFFFFFFFF,
      latch: 16'h0000, pull_en: 16'h0000, pull_up: 16'hFFFF, mask: 16'hFFFF,
      open_drain: 2'h0
   };

endpackage : ioxp_pkg

// ---- dv/ioxp_expander_sva.sv ----
module ioxp_expander_chk (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic RESET_N,
   input wire logic SCL_I,
   input wire logic SDA_O,
   input wire logic SDA_OE_N,
   input wire logic INT_O,
   input wire logic INT_OE_N,
   input wire logic [15:0] P_O,
   input wire logic [15:0] P_OE_N,
   input wire logic [31:0] P_DRIVE,
   input wire logic [15:0] P_PULL_EN,
   input wire logic [15:0] P_PULL_UP
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   //////////
   property p_pins_in_reset;
      $fell(RST) |-> P_OE_N == 16'hFFFF && P_PULL_EN == 16'h0000;
   endproperty
   a_pins_in_reset: assert property (p_pins_in_reset) else $error("pins not inputs after reset");
   property p_mask_reset;
      $fell(RST) |-> INT_OE_N [*8];
   endproperty
   a_mask_reset: assert property (p_mask_reset) else $error("alert while masks default");
   property p_pin_reset;
      !RESET_N [*4] |=> P_OE_N == 16'hFFFF && P_O == 16'hFFFF && INT_OE_N && SDA_OE_N;
   endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("reset pin did not clear outputs");
   property p_regs_reset;
      $fell(RST) |-> SDA_OE_N && P_DRIVE == 32'hFFFFFFFF && P_O == 16'hFFFF && P_PULL_UP == 16'hFFFF;
   endproperty
   a_regs_reset: assert property (p_regs_reset) else $error("register defaults wrong");
   property p_open_drain;
      SDA_O == 1'b0 && INT_O == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("open drain output drove high");
   // config only moves on bus writes, which land while the bus clock is low
   property p_cfg_idle;
      (SCL_I && RESET_N) [*8] |-> $stable(P_O) && $stable(P_OE_N) && $stable(P_DRIVE) && $stable(P_PULL_EN)
         && $stable(P_PULL_UP);
   endproperty
   a_cfg_idle: assert property (p_cfg_idle) else $error("config changed without bus write");
   property p_sda_edge;
      $changed(SDA_OE_N) |-> !SCL_I;
   endproperty
   a_sda_edge: assert property (p_sda_edge) else $error("data line moved while bus clock high");
   property p_mask_pin_reset;
      !RESET_N [*4] ##1 RESET_N |-> INT_OE_N [*8];
   endproperty
   a_mask_pin_reset: assert property (p_mask_pin_reset) else $error("alert after reset pin");
   c_alert: cover property ($fell(INT_OE_N));
   c_alert_clear: cover property ($rose(INT_OE_N));
   c_ack: cover property ($fell(SDA_OE_N));
endmodule // ioxp_expander_chk

bind ioxp_expander ioxp_expander_chk ioxp_expander_chk_i (.CLOCK(CLOCK), .RST(RST), .RESET_N(RESET_N),
   .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N), .INT_O(INT_O), .INT_OE_N(INT_OE_N), .P_O(P_O),
   .P_OE_N(P_OE_N), .P_DRIVE(P_DRIVE), .P_PULL_EN(P_PULL_EN), .P_PULL_UP(P_PULL_UP));

// ---- dv/ioxp_ctl_model.sv ----
module ioxp_ctl_model (
   input wire logic clk,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   logic sda_drv;
   // pull-up: released line reads high
   assign sda = sda_drv & (sda_oe_n | sda_o);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic hc();
      repeat (4) @(negedge clk);
   endtask
   task automatic bitio(input logic b, output logic r);
      sda_drv = b;
      hc();
      scl = 1'b1;
      hc();
      r = sda;
      hc();
      scl = 1'b0;
      hc();
   endtask
   task automatic start();
      sda_drv = 1'b1;
      hc();
      scl = 1'b1;
      hc();
      sda_drv = 1'b0;
      hc();
      scl = 1'b0;
      hc();
   endtask
   // clock left standing high between frames
   task automatic stop();
      sda_drv = 1'b0;
      hc();
      scl = 1'b1;
      hc();
      sda_drv = 1'b1;
      hc();
   endtask
   task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bitio(d[i], q[i]);
      bitio(mack, a);
      ack = ~a;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d, output logic ok);
      logic [7:0] q;
      logic k1, k2, k3, k4;
      start();
      xfer({a, 1'b0}, 1'b1, q, k1);
      xfer(c, 1'b1, q, k2);
      xfer(d[7:0], 1'b1, q, k3);
      xfer(d[15:8], 1'b1, q, k4);
      stop();
      ok = k1 & k2 & k3 & k4;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d, output logic ok);
      logic [7:0] q;
      logic k1, k2, k3, k4;
      start();
      xfer({a, 1'b0}, 1'b1, q, k1);
      xfer(c, 1'b1, q, k2);
      start();
      xfer({a, 1'b1}, 1'b1, q, k3);
      xfer(8'hFF, 1'b0, d[7:0], k4);
      xfer(8'hFF, 1'b1, d[15:8], k4);
      stop();
      ok = k1 & k2 & k3;
   endtask
endmodule // ioxp_ctl_model

// ---- dv/ioxp_expander_tb.sv ----
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_total++; \
   $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module ioxp_expander_tb;
   import ioxp_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock, rst, reset_n, addr_sel, scl, sda, sda_o, sda_oe_n, int_o, int_oe_n, ok;
   logic [15:0] p_i, p_o, p_oe_n, p_pull_en, p_pull_up, rv;
   logic [31:0] p_drive;
   int err_total, checked;
   logic [7:0] tc [9] = '{CMD_OUTPUT0, CMD_DIR0, CMD_POLARITY0, CMD_DRIVE0, CMD_DRIVE2, CMD_PULLEN0,
      CMD_PULLUP0, CMD_OUTTYPE, CMD_LATCH0};
   logic [15:0] tv [9] = '{16'hA55A, 16'h00FF, 16'h00FF, 16'h1234, 16'h5678, 16'h0F0F, 16'h3C3C, 16'h0002, 16'h0000};
   ioxp_expander ioxp_expander_i (.CLOCK(clock), .RST(rst), .RESET_N(reset_n), .ADDR_SEL(addr_sel), .SCL_I(scl),
      .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .INT_O(int_o), .INT_OE_N(int_oe_n), .P_I(p_i), .P_O(p_o),
      .P_OE_N(p_oe_n), .P_DRIVE(p_drive), .P_PULL_EN(p_pull_en), .P_PULL_UP(p_pull_up));
   ioxp_ctl_model ioxp_ctl_model_i (.clk(clock), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   //////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      ioxp_ctl_model_i.wr(TARGET_ADDR_LOW, c, d, ok);
      `CHK("write ack", 1'b1, ok)
   endtask
   task automatic chk_rd(input string nm, input logic [7:0] c, input logic [15:0] e);
      ioxp_ctl_model_i.rd(TARGET_ADDR_LOW, c, rv, ok);
      `CHK(nm, e, rv)
   endtask
   // bounded: a stuck alert must not hang the run
   task automatic wait_int(input logic lvl);
      int n;
      n = 0;
      while (int_oe_n !== lvl && n < 60) begin
         @(negedge clock);
         n++;
      end
      `CHK("int_oe_n", lvl, int_oe_n)
      if (int_oe_n !== lvl) tally_and_finish();
   endtask
   //////////
   initial begin
      rst = 1'b1;
      reset_n = 1'b1;
      addr_sel = 1'b0;
      p_i = 16'h0000;
      err_total = 0;
      checked = 0;
      repeat (8) @(negedge clock);
      rst = 1'b0;
      repeat (6) @(negedge clock);
      `CHK("p_oe_n", 16'hFFFF, p_oe_n)
      `CHK("defaults", {16'hFFFF, 16'h0000, 16'hFFFF, 32'hFFFFFFFF, 2'h3},
         {p_o, p_pull_en, p_pull_up, p_drive, int_oe_n, sda_oe_n})
      for (int s = 0; s < 2; s++) begin
         addr_sel = s[0];
         repeat (4) @(negedge clock);
         ioxp_ctl_model_i.rd(TARGET_ADDR_HIGH, CMD_DIR0, rv, ok);
         `CHK("ack high", s[0], ok)
         ioxp_ctl_model_i.rd(TARGET_ADDR_LOW, CMD_DIR0, rv, ok);
         `CHK("ack low", ~s[0], ok)
      end
      addr_sel = 1'b0;
      chk_rd("mask", CMD_MASK0, 16'hFFFF);
      chk_rd("dir", CMD_DIR0, 16'hFFFF);
      for (int i = 0; i < 9; i++) begin
         wr(tc[i], tv[i]);
         chk_rd("readback", tc[i], tv[i]);
      end
      `CHK("p_o", 16'hA55A, p_o)
      `CHK("p_oe_n", 16'hA5FF, p_oe_n)
      `CHK("p_drive", 32'h56781234, p_drive)
      `CHK("pulls", 32'h0F0F3C3C, {p_pull_en, p_pull_up})
      p_i = 16'h1234;
      chk_rd("inverted input", CMD_INPUT0, 16'h12CB);
      wr(CMD_POLARITY0, 16'h0000);
      wr(CMD_MASK0, 16'hFFFE);
      p_i[0] = 1'b1;
      wait_int(1'b0);
      chk_rd("status", CMD_STATUS0, 16'h0001);
      p_i[0] = 1'b0;
      wait_int(1'b1);
      p_i[0] = 1'b1;
      wait_int(1'b0);
      chk_rd("input", CMD_INPUT0, 16'h1235);
      `CHK("int_oe_n", 1'b1, int_oe_n)
      wr(CMD_LATCH0, 16'h0002);
      wr(CMD_MASK0, 16'hFFFC);
      p_i[1] = 1'b1;
      repeat (10) @(negedge clock);
      p_i[1] = 1'b0;
      wait_int(1'b0);
      chk_rd("latched", CMD_INPUT0, 16'h1237);
      reset_n = 1'b0;
      repeat (6) @(negedge clock);
      reset_n = 1'b1;
      repeat (4) @(negedge clock);
      `CHK("p_oe_n", 16'hFFFF, p_oe_n)
      chk_rd("dir", CMD_DIR0, 16'hFFFF);
      chk_rd("mask", CMD_MASK0, 16'hFFFF);
      tally_and_finish();
   end
endmodule // ioxp_expander_tb
